// [pwm_cfg.svh]
// Register offsets, field positions and reset values of the single channel modulator.
// Assumes it is included by bare name from the design module.
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH

`define PWM_CTRL_ADDR 8'h2D
`define PWM_DUTY_ADDR 8'h2E
`define PWM_PERIOD_ADDR 8'h2F

`define PWM_RUN_BIT 7
`define PWM_POL_BIT 6
`define PWM_CYCLE_BIT 4
`define PWM_RATE_MSB 3
`define PWM_RATE_LSB 0

`define PWM_CTRL_RST 8'h00
`define PWM_DUTY_RST 8'h00
`define PWM_PERIOD_RST 8'hFF
`define PWM_RATE_RST 4'h0

`define PWM_ACC_STEP 10'h002
`define PWM_ACC_RST 10'h000

`endif

// [single_channel_pwm_pkg.sv]
// Types shared by the single channel modulator and its users.
// Assumes nothing of its surroundings.
package single_channel_pwm_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic wrStrobe;
        logic rdStrobe;
    } reg_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_HALT = 2'b10
    } mod_state_t;

endpackage

// [single_channel_pwm.sv]
// Single channel pulse width modulator with control, duty and period registers.
// Assumes a single 20 MHz clock, synchronous inputs and a master that never overlaps strobes.
//
// How it works
// - Frame is modulator clock over period plus one.
// - Period spans one to 256 modulator clocks.
// - Eight-bit duty and period registers exist.
// - Zero duty inactive; full values give 255/256.
// - Polarity set with zero duty gives constant high.
// - Control bit 7 runs or stops the modulator.
// - Setting run starts generation at once.
// - Polarity chooses high or low active pulse.
// - Duty write copies polarity into shadow bit.
// - New values load at start or cycle end.
// - Cycle-end reload sets cycle flag; writing one clears.
// - Rate field picks one of sixteen divisors.
// - Duty above period holds output passive.
// - Period writes apply after current cycle.
// - All registers readable and writable anytime.
// - Wait mode leaves the modulator running.
// - Stop mode freezes and abandons the pulse.
// - Reset clears controls, zero duty, output high.
`timescale 1ns/1ps
`include "pwm_cfg.svh"

module single_channel_pwm #(
    parameter int DATA_W = 8,
    parameter int RATE_W = 4
) (
    input wire logic clk, // System clock, 20 MHz.
    input wire logic srst, // Synchronous reset, active high.
    input wire single_channel_pwm_pkg::reg_req_t regReq, // Register access request.
    output logic [DATA_W-1:0] rdData, // Read data, valid the cycle after a read.
    input wire logic stopMode, // High while the oscillator is halted.
    output logic pwmOut // Modulated output.
);

    logic runQ;
    logic polQ;
    logic cycleQ;
    logic [RATE_W-1:0] rateQ;
    logic [DATA_W-1:0] dutyQ;
    logic [DATA_W-1:0] periodQ;
    logic polShadowQ;
    logic [DATA_W-1:0] dutyActQ;
    logic [DATA_W-1:0] periodActQ;
    logic polActQ;
    logic [DATA_W-1:0] cntQ;
    logic [9:0] accQ;
    logic [9:0] accSum;
    logic [9:0] divHalf;
    single_channel_pwm_pkg::mod_state_t stateQ;
    single_channel_pwm_pkg::mod_state_t stateD;
    logic pwmOutQ;
    logic pwmOutD;
    logic [DATA_W-1:0] rdDataQ;
    logic [DATA_W-1:0] ctrlView;
    logic wrCtrl;
    logic wrDuty;
    logic wrPeriod;
    logic startEvt;
    logic tick;
    logic cycleEnd;
    logic activePhase;

    assign wrCtrl = regReq.wrStrobe && (regReq.addr == `PWM_CTRL_ADDR);
    assign wrDuty = regReq.wrStrobe && (regReq.addr == `PWM_DUTY_ADDR);
    assign wrPeriod = regReq.wrStrobe && (regReq.addr == `PWM_PERIOD_ADDR);

    // Divisor expressed in half oscillator clocks so that 1.5 stays exact.
    always_comb begin
        case (rateQ)
            4'h0: divHalf = 10'h002;
            4'h1: divHalf = 10'h003;
            4'h2: divHalf = 10'h004;
            4'h3: divHalf = 10'h006;
            4'h4: divHalf = 10'h008;
            4'h5: divHalf = 10'h00C;
            4'h6: divHalf = 10'h010;
            4'h7: divHalf = 10'h018;
            4'h8: divHalf = 10'h020;
            4'h9: divHalf = 10'h030;
            4'hA: divHalf = 10'h040;
            4'hB: divHalf = 10'h060;
            4'hC: divHalf = 10'h080;
            4'hD: divHalf = 10'h0C0;
            4'hE: divHalf = 10'h100;
            4'hF: divHalf = 10'h180;
            default: divHalf = 10'h002;
        endcase
    end

    // The rate field is used live, so a change mid cycle bends the current frame.
    assign accSum = accQ + `PWM_ACC_STEP;
    assign tick = (stateQ == single_channel_pwm_pkg::ST_RUN) && !stopMode && (accSum >= divHalf);
    assign cycleEnd = tick && (cntQ == periodActQ);
    assign startEvt = (stateQ == single_channel_pwm_pkg::ST_IDLE) && runQ && !stopMode;

    always_comb begin
        stateD = stateQ;
        case (stateQ)
            single_channel_pwm_pkg::ST_IDLE: begin
                if (startEvt) begin
                    stateD = single_channel_pwm_pkg::ST_RUN;
                end
            end
            single_channel_pwm_pkg::ST_RUN: begin
                if (!runQ) begin
                    stateD = single_channel_pwm_pkg::ST_IDLE;
                end else if (stopMode) begin
                    stateD = single_channel_pwm_pkg::ST_HALT;
                end
            end
            single_channel_pwm_pkg::ST_HALT: begin
                if (!stopMode) begin
                    stateD = single_channel_pwm_pkg::ST_IDLE;
                end
            end
            default: stateD = single_channel_pwm_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stateQ <= single_channel_pwm_pkg::ST_IDLE;
        end else begin
            stateQ <= stateD;
        end
    end

    // Control register; wait mode has no input because it changes nothing here.
    always_ff @(posedge clk) begin
        if (srst) begin
            runQ <= 1'b0;
            polQ <= 1'b0;
            rateQ <= `PWM_RATE_RST;
        end else if (wrCtrl) begin
            runQ <= regReq.wrData[`PWM_RUN_BIT];
            polQ <= regReq.wrData[`PWM_POL_BIT];
            rateQ <= regReq.wrData[`PWM_RATE_MSB:`PWM_RATE_LSB];
        end
    end

    // A reload in the same cycle as a clearing write keeps the flag set.
    always_ff @(posedge clk) begin
        if (srst) begin
            cycleQ <= 1'b0;
        end else if (cycleEnd) begin
            cycleQ <= 1'b1;
        end else if (wrCtrl && regReq.wrData[`PWM_CYCLE_BIT]) begin
            cycleQ <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dutyQ <= `PWM_DUTY_RST;
            polShadowQ <= 1'b0;
        end else if (wrDuty) begin
            dutyQ <= regReq.wrData;
            polShadowQ <= polQ;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            periodQ <= `PWM_PERIOD_RST;
        end else if (wrPeriod) begin
            periodQ <= regReq.wrData;
        end
    end

    // Working copies change only at start or at the end of a frame.
    always_ff @(posedge clk) begin
        if (srst) begin
            dutyActQ <= `PWM_DUTY_RST;
            periodActQ <= `PWM_PERIOD_RST;
            polActQ <= 1'b0;
        end else if (startEvt || cycleEnd) begin
            dutyActQ <= dutyQ;
            periodActQ <= periodQ;
            polActQ <= polShadowQ;
        end
    end

    // Prescaler accumulator; frozen while the oscillator is stopped.
    always_ff @(posedge clk) begin
        if (srst || startEvt) begin
            accQ <= `PWM_ACC_RST;
        end else if (tick) begin
            accQ <= accSum - divHalf;
        end else if ((stateQ == single_channel_pwm_pkg::ST_RUN) && !stopMode) begin
            accQ <= accSum;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || startEvt) begin
            cntQ <= '0;
        end else if (cycleEnd) begin
            cntQ <= '0;
        end else if (tick) begin
            cntQ <= cntQ + 1'b1;
        end
    end

    assign activePhase = (cntQ < dutyActQ) && (dutyActQ <= periodActQ);

    always_comb begin
        pwmOutD = pwmOutQ;
        case (stateQ)
            single_channel_pwm_pkg::ST_IDLE: pwmOutD = 1'b1;
            single_channel_pwm_pkg::ST_HALT: pwmOutD = pwmOutQ;
            single_channel_pwm_pkg::ST_RUN: begin
                if (stopMode) begin
                    pwmOutD = pwmOutQ;
                end else if (polActQ && (dutyActQ == '0)) begin
                    pwmOutD = 1'b1;
                end else if (activePhase) begin
                    pwmOutD = polActQ;
                end else begin
                    pwmOutD = !polActQ;
                end
            end
            default: pwmOutD = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pwmOutQ <= 1'b1;
        end else begin
            pwmOutQ <= pwmOutD;
        end
    end

    assign ctrlView = {runQ, polQ, 1'b0, cycleQ, rateQ};

    // Read data stands for exactly one cycle; unmapped addresses read zero.
    always_ff @(posedge clk) begin
        if (srst || !regReq.rdStrobe) begin
            rdDataQ <= '0;
        end else begin
            case (regReq.addr)
                `PWM_CTRL_ADDR: rdDataQ <= ctrlView;
                `PWM_DUTY_ADDR: rdDataQ <= dutyQ;
                `PWM_PERIOD_ADDR: rdDataQ <= periodQ;
                default: rdDataQ <= '0;
            endcase
        end
    end

    assign rdData = rdDataQ;
    assign pwmOut = pwmOutQ;

endmodule // single_channel_pwm

// [single_channel_pwm_assertions.sv]
// Concurrent checks on the ports of the single channel modulator.
// Assumes it is bound to single_channel_pwm and sees only its ports.
`timescale 1ns/1ps
module single_channel_pwm_assertions (
    input wire logic clk, // System clock.
    input wire logic srst, // Synchronous reset.
    input wire single_channel_pwm_pkg::reg_req_t regReq, // Register request.
    input wire logic [7:0] rdData, // Read data.
    input wire logic stopMode, // Oscillator halted.
    input wire logic pwmOut // Modulated output.
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property readBack(logic [7:0] a, logic [7:0] m);
        regReq.wrStrobe && regReq.addr == a ##1 regReq.rdStrobe && regReq.addr == a
            |=> (rdData & m) == ($past(regReq.wrData, 2) & m);
    endproperty
    AST_RST_IDLE: assert property ($fell(srst) |-> pwmOut && rdData == 8'h00)
        else $error("output or read data wrong after reset");
    AST_RD_QUIET: assert property (!regReq.rdStrobe |=> rdData == 8'h00)
        else $error("read data not zero without a read");
    AST_CTRL_GAP: assert property (regReq.rdStrobe && regReq.addr == 8'h2D |=> !rdData[5])
        else $error("control bit 5 reads one");
    AST_CTRL_RB: assert property (readBack(8'h2D, 8'hCF))
        else $error("control readback wrong");
    AST_DUTY_RB: assert property (readBack(8'h2E, 8'hFF))
        else $error("duty readback wrong");
    AST_PERIOD_RB: assert property (readBack(8'h2F, 8'hFF))
        else $error("period readback wrong");
    AST_STOP_HOLD: assert property (stopMode |=> pwmOut == $past(pwmOut))
        else $error("output moved in stop mode");
    AST_OFF_HIGH: assert property (regReq.wrStrobe && regReq.addr == 8'h2D && !regReq.wrData[7]
        ##1 (!stopMode && !regReq.wrStrobe)[*2] |=> pwmOut)
        else $error("stopped modulator output not high");
    cover property (regReq.wrStrobe && regReq.addr == 8'h2D && regReq.wrData[7]);
    cover property (stopMode && !pwmOut);
    cover property ($rose(pwmOut));
endmodule // single_channel_pwm_assertions

bind single_channel_pwm single_channel_pwm_assertions single_channel_pwm_assertions_i (
    .clk(clk), .srst(srst), .regReq(regReq), .rdData(rdData), .stopMode(stopMode),
    .pwmOut(pwmOut));

// [single_channel_pwm_tb.sv]
// Self-checking bench for the single channel modulator.
// Assumes the design and its checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module single_channel_pwm_tb;
    logic clk = 0;
    logic srst = 1;
    logic stopMode = 0;
    logic pwmOut;
    logic [7:0] rdData;
    logic [7:0] got;
    logic [7:0] seed = 8'h2E;
    int failures = 0;
    int num_checks = 0;
    single_channel_pwm_pkg::reg_req_t regReq = '0;
    single_channel_pwm single_channel_pwm_i (.clk(clk), .srst(srst), .regReq(regReq),
        .rdData(rdData), .stopMode(stopMode), .pwmOut(pwmOut));
    initial begin
        forever #25 clk = ~clk;
    end
    function automatic logic [7:0] lfsr(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic level(logic pulse_polarity, logic [7:0] d, logic [7:0] p, int k);
        if (pulse_polarity && d == 8'h00) return 1'b1;
        if (d > p) return !pulse_polarity;
        return (k < d) ? pulse_polarity : !pulse_polarity;
    endfunction
    // Called at a rising edge; read data are taken at the edge after the strobe edge.
    task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
        regReq <= '{addr: a, wrData: d, wrStrobe: w, rdStrobe: !w};
        @(posedge clk);
        regReq <= '{addr: a, wrData: d, wrStrobe: 1'b0, rdStrobe: 1'b0};
        @(posedge clk);
        got = rdData;
    endtask
    // A write followed with no gap by a read of the same register.
    task automatic wrrd(logic [7:0] a, logic [7:0] d);
        regReq <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
        @(posedge clk);
        regReq <= '{addr: a, wrData: d, wrStrobe: 1'b0, rdStrobe: 1'b1};
        @(posedge clk);
        regReq <= '{addr: a, wrData: d, wrStrobe: 1'b0, rdStrobe: 1'b0};
        @(posedge clk);
        got = rdData;
    endtask
    // Runs two frames at an integer divisor and compares every cycle.
    task automatic frame(logic pulse_polarity, logic [1:0] r, logic [7:0] d, logic [7:0] p);
        int dv;
        dv = (r == 2'd0) ? 1 : int'(r);
        bus(1'b1, 8'h2D, {1'b0, pulse_polarity, 6'h00});
        bus(1'b1, 8'h2E, d);
        bus(1'b1, 8'h2F, p);
        bus(1'b1, 8'h2D, {1'b1, pulse_polarity, 4'h0, r});
        repeat (2) @(posedge clk);
        for (int i = 0; i < 2 * dv * (p + 1); i++) begin
            `CHK(pwmOut, level(pulse_polarity, d, p, (i / dv) % (p + 1)))
            @(posedge clk);
        end
        wrrd(8'h2D, {1'b0, pulse_polarity, 4'h0, r});
        `CHK(got, {1'b0, pulse_polarity, 2'b01, 2'b00, r})
        wrrd(8'h2D, 8'h10);
        `CHK(got, 8'h00)
    endtask
    task automatic results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        results();
    end
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK(pwmOut, 1'b1)
        bus(1'b0, 8'h2D, 8'h00);
        `CHK(got, 8'h00)
        bus(1'b0, 8'h2E, 8'h00);
        `CHK(got, 8'h00)
        bus(1'b0, 8'h2F, 8'h00);
        `CHK(got, 8'hFF)
        bus(1'b0, 8'h30, 8'h00);
        `CHK(got, 8'h00)
        wrrd(8'h2E, 8'hA5);
        `CHK(got, 8'hA5)
        wrrd(8'h2F, 8'h3C);
        `CHK(got, 8'h3C)
        frame(1'b1, 2'd0, 8'h01, 8'h01);
        frame(1'b1, 2'd0, 8'h00, 8'h05);
        frame(1'b0, 2'd0, 8'h00, 8'h05);
        frame(1'b1, 2'd0, 8'h09, 8'h05);
        frame(1'b0, 2'd3, 8'h03, 8'h04);
        frame(1'b1, 2'd0, 8'hFF, 8'hFF);
        for (int n = 0; n < 5; n++) begin
            seed = lfsr(seed);
            got = lfsr(seed);
            seed = lfsr(got);
            frame(seed[7], {seed[0], 1'b0}, got, seed);
        end
        bus(1'b1, 8'h2D, 8'hC0);
        repeat (3) @(posedge clk);
        stopMode <= 1'b1;
        @(posedge clk);
        got[0] = pwmOut;
        repeat (4) @(posedge clk);
        `CHK(pwmOut, got[0])
        stopMode <= 1'b0;
        results();
    end
endmodule // single_channel_pwm_tb
